//--- verilog/tdm_port_pkg.sv
// Constants, register map and carrier types for the backplane frame port.
// Assumes a single 100 MHz system clock and a classic Wishbone master.
`default_nettype none

package tdm_port_pkg;

	// Clock rates and frame geometry
	localparam int CLK_FREQ_HZ = 100_000_000;
	localparam int DCL_FREQ_HZ = 512_000;
	localparam int FRAME_HZ = 8_000;
	localparam int DCL_PER_FRAME = DCL_FREQ_HZ / FRAME_HZ;
	localparam logic [6:0] DCL_HALF_CYC =
		7'(CLK_FREQ_HZ / (2 * DCL_FREQ_HZ));
	localparam logic [6:0] DIV_ZERO = 7'h00;
	localparam logic [5:0] HALF_FRAME = 6'(DCL_PER_FRAME / 2);
	localparam logic [5:0] FRAME_FIRST = 6'h00;
	localparam logic [5:0] CNT_STEP = 6'h01;
	localparam logic [5:0] FSD_DELAY = 6'h08;
	localparam logic [1:0] PA_BIT_LAST = 2'h3;
	localparam logic [1:0] PA_BIT_FIRST = 2'h0;

	// Octet contents
	localparam logic [7:0] IDLE_OCTET = 8'hFF;
	localparam int MON_STOPGO_POS = 4;

	// Register indexes; byte address is four times the index
	localparam logic [5:0] IDX_SPC = 6'h30;
	localparam logic [5:0] IDX_SIG = 6'h33;
	localparam logic [5:0] IDX_FC = 6'h34;
	localparam logic [5:0] IDX_CH1 = 6'h35;
	localparam logic [5:0] IDX_CH2 = 6'h36;
	localparam logic [5:0] IDX_STC = 6'h37;
	localparam logic [5:0] IDX_ADF = 6'h38;
	localparam logic [5:0] IDX_STAT = 6'h39;
	localparam logic [5:0] IDX_CAP1 = 6'h3A;
	localparam logic [5:0] IDX_CAP2 = 6'h3B;
	localparam logic [5:0] IDX_CMD = 6'h3C;
	localparam logic [5:0] IDX_IND = 6'h3D;
	localparam logic [5:0] IDX_CIRX = 6'h3E;

	// Connect codes of one B channel
	localparam logic [1:0] CONN_LINK_LOOP = 2'b00;
	localparam logic [1:0] CONN_LINK_BP = 2'b01;
	localparam logic [1:0] CONN_PORTA_BP = 2'b10;
	localparam logic [1:0] CONN_BP_LOOP = 2'b11;

	// Serial port control: bits 1:0 B1 connect, 3:2 B2 connect, 4 timing
	typedef struct packed {
		logic tmode;
		logic [1:0] conn2;
		logic [1:0] conn1;
	} spc_s;

	// Extra features: 0/1 strobe polarity, 2 wide port A, 3 terminal, 4 mode
	typedef struct packed {
		logic interface_mode_select;
		logic term;
		logic wide;
		logic pol_b;
		logic pol_a;
	} adf_s;

	// Sync transfer control: bit 0 enable, bit 1 mid-frame
	typedef struct packed {
		logic mid;
		logic en;
	} stc_s;

	localparam spc_s SPC_RST = '0;
	localparam adf_s ADF_RST = '0;
	localparam stc_s STC_RST = '0;

	// Status word bit positions
	localparam int STAT_BVALID = 0;
	localparam int STAT_STOPGO = 1;

	// Wishbone carriers
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_s;

endpackage

`default_nettype wire

//--- verilog/tdm_frame_port.sv
// Backplane frame port with ping-pong link, serial port A and B switch.
// Assumes pins are asynchronous to clk_in and a Wishbone classic master.
//
// The Wishbone register port was chosen for this implementation.
`default_nettype none

module tdm_frame_port (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Register bus
	input wire tdm_port_pkg::wb_req_s wb_req_in,
	output logic [32:0] wb_rsp_out,
	// Backplane clocks
	input wire logic bit_clock_in,
	output logic bit_clock_out,
	output logic bit_clock_oe_n_out,
	input wire logic frame_sync_a_in,
	output logic frame_sync_a_out,
	output logic frame_sync_a_oe_n_out,
	input wire logic frame_sync_b_in,
	output logic frame_sync_b_out,
	output logic frame_sync_b_oe_n_out,
	// Backplane data
	output logic downstream_data_line_out,
	input wire logic upstream_data_line_in,
	output logic upstream_data_line_out,
	output logic upstream_data_line_oe_n_out,
	// Ping-pong link
	input wire logic bidir_data_lead_in,
	output logic bidir_data_lead_out,
	output logic bidir_data_lead_oe_n_out,
	// Serial port A
	output logic port_a_tx_line_out,
	input wire logic port_a_rx_line_in,
	output logic port_a_clock_out,
	// Layer 1 status and sync transfer event
	input wire logic d_channel_stop_in,
	output logic sync_transfer_irq_out
);
	import tdm_port_pkg::*;

	typedef struct packed {
		logic [2:0] dcl_s, fsa_s, fsb_s, up_s, lead_s, parx_s, sg_s;
		logic [6:0] div;
		logic gen_dcl;
		logic fs_pend;
		logic fsa_pend;
		logic [5:0] cnt;
		logic [5:0] fsd_cnt;
		spc_s spc;
		adf_s adf;
		stc_s stc;
		logic bvalid;
		logic [7:0] ch1_tx, ch2_tx, fc_tx, sig_tx, cmd_tx, ind_tx;
		logic [7:0] cap1, cap2, lk1, lk2, fc_rx, sig_rx, pa1, pa2, ci_rx;
		logic [31:0] up_sh, lead_sh;
		logic [15:0] pa_sh;
		logic [31:0] down_fr, up_fr, link_fr;
		logic [15:0] pa_fr;
		logic down_o, up_o, up_oe_n, lead_o, lead_oe_n, pa_tx, pa_clk;
		logic dcl_oe_n, fsa_o, fsb_o, fs_oe_n, irq, fstart;
		wb_rsp_s rsp;
	} state_s;

	state_s st;
	state_s n;

	// Octet sent toward the backplane for one channel
	function automatic logic [7:0] to_backplane(input logic [1:0] conn,
		input logic [7:0] lk, input logic [7:0] pa, input logic [7:0] up);
		case (conn)
			CONN_LINK_LOOP: to_backplane = IDLE_OCTET;
			CONN_LINK_BP: to_backplane = lk;
			CONN_PORTA_BP: to_backplane = pa;
			default: to_backplane = up;
		endcase
	endfunction

	// Octet sent on the link for one channel
	function automatic logic [7:0] to_link(input logic [1:0] conn,
		input logic [7:0] cpu, input logic [7:0] up);
		to_link = (conn == CONN_LINK_BP) ? up : cpu;
	endfunction

	// Octet sent on port A for one channel
	function automatic logic [7:0] to_porta(input logic [1:0] conn,
		input logic [7:0] up);
		to_porta = (conn == CONN_PORTA_BP) ? up : IDLE_OCTET;
	endfunction

	// Octet that software reads from a channel register
	function automatic logic [7:0] chan_read(input logic [1:0] conn,
		input logic [7:0] lk, input logic [7:0] pa, input logic [7:0] up);
		case (conn)
			CONN_LINK_LOOP, CONN_LINK_BP: chan_read = lk;
			CONN_PORTA_BP: chan_read = pa;
			default: chan_read = up;
		endcase
	endfunction

	logic rise_evt;
	logic fall_evt;
	logic fs_rise;
	logic fsa_rise;
	logic restart;
	logic newframe;
	logic link_tx_half;
	logic [5:0] c;
	logic [5:0] fsd_off;
	logic [1:0] conn2_eff;
	logic [5:0] idx;
	logic [7:0] mon_down;

	always_comb begin
		n = st;
		rise_evt = 1'b0;
		fall_evt = 1'b0;
		fs_rise = 1'b0;
		fsa_rise = 1'b0;
		restart = 1'b0;
		newframe = 1'b0;
		link_tx_half = 1'b0;
		c = st.cnt;
		fsd_off = 6'h00;
		conn2_eff = st.spc.conn2;
		idx = st.rsp.dat[5:0];
		mon_down = IDLE_OCTET;
		if (sys_rst_in) begin
			n = '0;
			n.spc = SPC_RST;
			n.adf = ADF_RST;
			n.stc = STC_RST;
			n.cmd_tx = IDLE_OCTET;
			n.ind_tx = IDLE_OCTET;
			n.up_oe_n = 1'b1;
			n.lead_oe_n = 1'b1;
			n.pa_tx = 1'b1;
			n.dcl_oe_n = 1'b1;
			n.fs_oe_n = 1'b1;
		end else begin
			// Pins pass two flops; the third stage only feeds edge detection
			n.dcl_s = {st.dcl_s[1:0], bit_clock_in};
			n.fsa_s = {st.fsa_s[1:0], frame_sync_a_in};
			n.fsb_s = {st.fsb_s[1:0], frame_sync_b_in};
			n.up_s = {st.up_s[1:0], upstream_data_line_in};
			n.lead_s = {st.lead_s[1:0], bidir_data_lead_in};
			n.parx_s = {st.parx_s[1:0], port_a_rx_line_in};
			n.sg_s = {st.sg_s[1:0], d_channel_stop_in};
			fsa_rise = st.fsa_s[1] & ~st.fsa_s[2];
			fs_rise = st.spc.tmode ? (st.fsb_s[1] & ~st.fsb_s[2]) : fsa_rise;
			// Terminal mode makes its own bit clock; the rate is truncated
			if (st.adf.term) begin
				if (st.div == DIV_ZERO) begin
					n.div = DCL_HALF_CYC - 7'h01;
					n.gen_dcl = ~st.gen_dcl;
					rise_evt = ~st.gen_dcl;
					fall_evt = st.gen_dcl;
				end else begin
					n.div = st.div - 7'h01;
				end
			end else begin
				n.gen_dcl = 1'b0;
				rise_evt = st.dcl_s[1] & ~st.dcl_s[2];
				fall_evt = ~st.dcl_s[1] & st.dcl_s[2];
				restart = fs_rise | st.fs_pend;
			end
			n.dcl_oe_n = ~st.adf.term;
			n.fs_oe_n = ~st.adf.term;
			if (fs_rise && !rise_evt) begin
				n.fs_pend = 1'b1;
			end
			// A sync edge rarely meets a bit clock edge; hold it until one
			if (fsa_rise && !rise_evt) begin
				n.fsa_pend = 1'b1;
			end
			// Counter of bit clock cycles in the frame, two per bit
			if (rise_evt) begin
				if (restart) begin
					n.cnt = FRAME_FIRST;
					n.fs_pend = 1'b0;
				end else begin
					n.cnt = st.cnt + CNT_STEP;
				end
				if (fsa_rise || st.fsa_pend) begin
					n.fsd_cnt = FRAME_FIRST;
					n.fsa_pend = 1'b0;
				end else begin
					n.fsd_cnt = st.fsd_cnt + CNT_STEP;
				end
			end
			c = n.cnt;
			newframe = rise_evt && (c == FRAME_FIRST);
			n.fstart = newframe;
			conn2_eff = st.adf.wide ? st.spc.conn1 : st.spc.conn2;
			// Frame boundary: take last frame's octets, build the next frame
			if (newframe) begin
				n.cap1 = st.up_sh[31:24];
				n.cap2 = st.up_sh[23:16];
				n.ci_rx = st.up_sh[7:0];
				n.lk1 = st.lead_sh[31:24];
				n.lk2 = st.lead_sh[23:16];
				n.fc_rx = st.lead_sh[15:8];
				n.sig_rx = st.lead_sh[7:0];
				n.pa1 = st.pa_sh[15:8];
				n.pa2 = st.pa_sh[7:0];
				mon_down[MON_STOPGO_POS] = st.sg_s[1];
				n.down_fr = {to_backplane(st.spc.conn1, n.lk1, n.pa1, n.cap1),
					to_backplane(conn2_eff, n.lk2, n.pa2, n.cap2),
					mon_down, st.ind_tx};
				n.up_fr = {IDLE_OCTET, IDLE_OCTET, IDLE_OCTET,
					st.cmd_tx};
				n.link_fr = {to_link(st.spc.conn1, st.ch1_tx, n.cap1),
					to_link(conn2_eff, st.ch2_tx, n.cap2),
					st.fc_tx, st.sig_tx};
				n.pa_fr = {to_porta(st.spc.conn1, n.cap1),
					to_porta(conn2_eff, n.cap2)};
			end
			// Drive points on the bit clock rise
			if (rise_evt) begin
				if (!c[0]) begin
					n.down_o = n.down_fr[5'd31 - c[5:1]];
					n.up_oe_n = n.up_fr[5'd31 - c[5:1]];
				end
				link_tx_half = (c < HALF_FRAME) ^ st.spc.tmode;
				if (link_tx_half && !st.adf.interface_mode_select) begin
					n.lead_o = n.link_fr[5'd31 - c[4:0]];
					n.lead_oe_n = 1'b0;
				end else begin
					n.lead_oe_n = 1'b1;
				end
				if (c[1:0] == PA_BIT_FIRST) begin
					n.pa_tx = n.pa_fr[4'd15 - c[5:2]];
				end
				// Strobes are high over B1 and B2, the first half frame; setting a polarity bit inverts one
				n.fsa_o = (c < HALF_FRAME) ^ st.adf.pol_a;
				n.fsb_o = (c < HALF_FRAME) ^ st.adf.pol_b;
			end
			if (st.spc.tmode || st.adf.interface_mode_select) begin
				n.pa_tx = 1'b1;
			end
			// Port A clock pin carries the delayed frame in timing mode 1
			fsd_off = st.fsd_cnt - FSD_DELAY;
			n.pa_clk = st.spc.tmode ? ~fsd_off[5] : ~st.cnt[1];
			// Sample points on the bit clock fall, in the last bit clock cycle of each bit
			if (fall_evt) begin
				if (st.cnt[0]) begin
					n.up_sh = {st.up_sh[30:0], st.up_s[1]};
				end
				if (!((st.cnt < HALF_FRAME) ^ st.spc.tmode)) begin
					n.lead_sh = {st.lead_sh[30:0], st.lead_s[1]};
				end
				if (st.cnt[1:0] == PA_BIT_LAST && !st.spc.tmode) begin
					n.pa_sh = {st.pa_sh[14:0], st.parx_s[1]};
				end
			end
			// Bus slave: one-cycle ack, unmapped reads give zero
			n.rsp.ack = 1'b0;
			n.irq = 1'b0;
			if (wb_req_in.cyc && wb_req_in.stb && !st.rsp.ack) begin
				n.rsp.ack = 1'b1;
				n.rsp.dat = '0;
				idx = wb_req_in.adr[7:2];
				if (wb_req_in.we && wb_req_in.sel[0]) begin
					if (idx == IDX_SPC) begin
						n.spc = spc_s'(wb_req_in.dat[4:0]);
					end else if (idx == IDX_SIG) begin
						n.sig_tx = wb_req_in.dat[7:0];
					end else if (idx == IDX_FC) begin
						n.fc_tx = wb_req_in.dat[7:0];
					end else if (idx == IDX_CH1) begin
						n.ch1_tx = wb_req_in.dat[7:0];
					end else if (idx == IDX_CH2) begin
						n.ch2_tx = wb_req_in.dat[7:0];
					end else if (idx == IDX_STC) begin
						n.stc = stc_s'(wb_req_in.dat[1:0]);
					end else if (idx == IDX_ADF) begin
						n.adf = adf_s'(wb_req_in.dat[4:0]);
					end else if (idx == IDX_CMD) begin
						n.cmd_tx = wb_req_in.dat[7:0];
					end else if (idx == IDX_IND) begin
						n.ind_tx = wb_req_in.dat[7:0];
					end
				end else if (!wb_req_in.we) begin
					if (idx == IDX_SPC) begin
						n.rsp.dat[4:0] = st.spc;
					end else if (idx == IDX_SIG) begin
						n.rsp.dat[7:0] = st.sig_rx;
					end else if (idx == IDX_FC) begin
						n.rsp.dat[7:0] = st.fc_rx;
					end else if (idx == IDX_CH1) begin
						n.rsp.dat[7:0] = chan_read(st.spc.conn1, st.lk1,
							st.pa1, st.cap1);
					end else if (idx == IDX_CH2) begin
						n.rsp.dat[7:0] = chan_read(conn2_eff, st.lk2,
							st.pa2, st.cap2);
					end else if (idx == IDX_STC) begin
						n.rsp.dat[1:0] = st.stc;
					end else if (idx == IDX_ADF) begin
						n.rsp.dat[4:0] = st.adf;
					end else if (idx == IDX_STAT) begin
						n.rsp.dat[STAT_BVALID] = st.bvalid;
						n.rsp.dat[STAT_STOPGO] = st.sg_s[1];
						n.bvalid = 1'b0;
					end else if (idx == IDX_CAP1) begin
						n.rsp.dat[7:0] = st.cap1;
					end else if (idx == IDX_CAP2) begin
						n.rsp.dat[7:0] = st.cap2;
					end else if (idx == IDX_CMD) begin
						n.rsp.dat[7:0] = st.cmd_tx;
					end else if (idx == IDX_IND) begin
						n.rsp.dat[7:0] = st.ind_tx;
					end else if (idx == IDX_CIRX) begin
						n.rsp.dat[7:0] = st.ci_rx;
					end
				end
			end
			// Sync transfer point; set wins over the status read clear
			if (rise_evt && st.stc.en &&
				c == (st.stc.mid ? HALF_FRAME : FRAME_FIRST)) begin
				n.irq = 1'b1;
				n.bvalid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		st <= n;
	end

	assign wb_rsp_out = st.rsp;
	assign bit_clock_out = st.gen_dcl;
	assign bit_clock_oe_n_out = st.dcl_oe_n;
	assign frame_sync_a_out = st.fsa_o;
	assign frame_sync_a_oe_n_out = st.fs_oe_n;
	assign frame_sync_b_out = st.fsb_o;
	assign frame_sync_b_oe_n_out = st.fs_oe_n;
	assign downstream_data_line_out = st.down_o;
	assign upstream_data_line_out = st.up_o;
	assign upstream_data_line_oe_n_out = st.up_oe_n;
	assign bidir_data_lead_out = st.lead_o;
	assign bidir_data_lead_oe_n_out = st.lead_oe_n;
	assign port_a_tx_line_out = st.pa_tx;
	assign port_a_clock_out = st.pa_clk;
	assign sync_transfer_irq_out = st.irq;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_idle_b1;
		st.fstart && $past(st.spc.conn1) == CONN_LINK_LOOP
			|-> st.down_fr[31:24] == IDLE_OCTET;
	endproperty
	a_idle_b1: assert property (p_idle_b1)
		else $error("B1 not idle with connect bits 00");

	property p_stopgo;
		st.fstart |-> st.down_fr[8 + MON_STOPGO_POS] == $past(st.sg_s[1]);
	endproperty
	a_stopgo: assert property (p_stopgo)
		else $error("stop/go bit does not follow layer 1");

	property p_mon_idle;
		st.fstart |-> st.up_fr[15:8] == IDLE_OCTET && st.up_fr[7:0] ==
			$past(st.cmd_tx);
	endproperty
	a_mon_idle: assert property (p_mon_idle)
		else $error("upstream monitor octet not idle");

	property p_count_step;
		$past(rise_evt) && !$past(restart) |-> st.cnt == $past(st.cnt) + 6'h01;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("bit counter did not advance");

	property p_count_restart;
		$past(rise_evt) && $past(restart) |-> st.cnt == FRAME_FIRST;
	endproperty
	a_count_restart: assert property (p_count_restart)
		else $error("bit counter not reset at frame sync");

	property p_irq_point;
		st.irq |-> $past(st.stc.en) && st.cnt ==
			($past(st.stc.mid) ? HALF_FRAME : FRAME_FIRST) ##1 !st.irq;
	endproperty
	a_irq_point: assert property (p_irq_point)
		else $error("sync transfer at wrong frame point");

	property p_porta_off;
		st.spc.tmode && $past(st.spc.tmode) |-> st.pa_tx;
	endproperty
	a_porta_off: assert property (p_porta_off)
		else $error("port A active in timing mode 1");

	property p_link_dir;
		$past(rise_evt) && !st.lead_oe_n |-> (st.cnt < HALF_FRAME) !=
			$past(st.spc.tmode) && !$past(st.adf.interface_mode_select);
	endproperty
	a_link_dir: assert property (p_link_dir)
		else $error("link lead driven in receive half");

	property p_clock_dir;
		!$past(st.adf.term) |-> st.dcl_oe_n && st.fs_oe_n;
	endproperty
	a_clock_dir: assert property (p_clock_dir)
		else $error("clock pins driven outside terminal mode");

	property p_cap_read;
		st.rsp.ack && !$past(wb_req_in.we) &&
			$past(wb_req_in.adr[7:2]) == IDX_CAP1
			|-> st.rsp.dat[7:0] == $past(st.cap1);
	endproperty
	a_cap_read: assert property (p_cap_read)
		else $error("capture read returned wrong octet");

	property p_ack_pulse;
		st.rsp.ack |=> !st.rsp.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held longer than one cycle");

	c_frame: cover property (st.fstart ##[1:1000] st.fstart);
	c_mode1: cover property (st.spc.tmode && st.fstart);
	c_irq_mid: cover property (st.irq && st.stc.mid);
	c_link_tx: cover property ($fell(st.lead_oe_n));

endmodule // tdm_frame_port

`default_nettype wire

//--- tb/backplane_partner.sv
// Far-side model of the backplane: clock source and layer-2 controller.
// Assumes the bench muxes these drivers against the block's own drivers.
`default_nettype none

module backplane_partner (
	// Lines seen from the controller
	input wire logic down_in,
	input wire logic up_oe_n_in,
	output logic bclk_out,
	output logic fsync_out,
	output logic up_wire_out,
	// Last whole frames, two samples a bit
	output logic [63:0] down_frame_out,
	output logic [63:0] up_frame_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] hc = 6'h00;
	logic up_drv = 1'h1;
	logic [63:0] ds = '0;
	logic [63:0] us = '0;
	logic fs_q = 1'h0;
	logic [63:0] dq = '0;
	logic [63:0] uq = '0;

	assign fsync_out = fs_q;
	assign down_frame_out = dq;
	assign up_frame_out = uq;

	// Pull-up makes the shared line a wired AND of all drivers
	assign up_wire_out = up_drv & up_oe_n_in;

	// Free-running bit clock, started off the system clock grid
	initial begin
		bclk_out = 1'h0;
		#37;
		forever #80 bclk_out = ~bclk_out;
	end

	// Symmetric sync, 64 bit clocks per four-octet frame
	always @(negedge bclk_out) begin
		ds[hc] = down_in;
		us[hc] = up_wire_out;
		if (hc == 6'h3F) begin
			dq <= ds;
			uq <= us;
		end
		fs_q <= (hc == 6'h3F) || (hc < 6'h1F);
		hc <= hc + 6'h01;
	end

	// Upstream B1 and B2 sent as zeros, changed away from sampling
	always @(posedge bclk_out) begin
		up_drv <= (hc > 6'h1F);
	end
endmodule // backplane_partner

`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the backplane frame port, registers on Wishbone.
// Assumes the partner model supplies bit clock, frame sync and upstream.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tdm_port_pkg::*;
	logic clk_in = 1'h0;
	logic sys_rst_in = 1'h1;
	wb_req_s wb_req = '0;
	logic [32:0] wb_rsp;
	logic bc_o, bc_oe_n, fa_o, fa_oe_n, fb_o, fb_oe_n, down, up_o, up_oe_n;
	logic ld_o, ld_oe_n, pa_tx, pa_clk, irq, p_bclk, p_fs, up_wire;
	logic [63:0] dfr, ufr;
	logic d_stop = 1'h0;
	logic link_drv = 1'h0;
	logic pa_rx = 1'h0;
	logic fsd_route = 1'h0;
	logic [7:0] q;
	int err_total = 0;
	int cmp_count = 0;
	int nirq, pirq, nrise, prise, nhi, ntx0, nld, nld1;

	always #5 clk_in = ~clk_in;

	tdm_frame_port tdm_frame_port_inst (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.wb_req_in(wb_req),
		.wb_rsp_out(wb_rsp),
		.bit_clock_in(bc_oe_n ? p_bclk : bc_o),
		.bit_clock_out(bc_o),
		.bit_clock_oe_n_out(bc_oe_n),
		.frame_sync_a_in(fa_oe_n ? p_fs : fa_o),
		.frame_sync_a_out(fa_o),
		.frame_sync_a_oe_n_out(fa_oe_n),
		.frame_sync_b_in(fb_oe_n ? (fsd_route ? pa_clk : p_fs) : fb_o),
		.frame_sync_b_out(fb_o),
		.frame_sync_b_oe_n_out(fb_oe_n),
		.downstream_data_line_out(down),
		.upstream_data_line_in(up_wire),
		.upstream_data_line_out(up_o),
		.upstream_data_line_oe_n_out(up_oe_n),
		.bidir_data_lead_in(ld_oe_n ? link_drv : ld_o),
		.bidir_data_lead_out(ld_o),
		.bidir_data_lead_oe_n_out(ld_oe_n),
		.port_a_tx_line_out(pa_tx),
		.port_a_rx_line_in(pa_rx),
		.port_a_clock_out(pa_clk),
		.d_channel_stop_in(d_stop),
		.sync_transfer_irq_out(irq)
	);

	backplane_partner backplane_partner_inst (
		.down_in(down),
		.up_oe_n_in(up_oe_n),
		.bclk_out(p_bclk),
		.fsync_out(p_fs),
		.up_wire_out(up_wire),
		.down_frame_out(dfr),
		.up_frame_out(ufr)
	);

	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask

	// One classic cycle; waits for ack however long it takes
	task automatic wb(input logic [5:0] idx, input logic we,
		input logic [7:0] d);
		int n = 0;
		wb_req <= '{1'h1, 1'h1, we, {idx, 2'h0}, 4'hF, {24'h000000, d}};
		@(posedge clk_in);
		while (wb_rsp[32] !== 1'h1) begin
			@(posedge clk_in);
			n++;
		end
		q = wb_rsp[7:0];
		check(n, 1, "bus answer latency");
		wb_req <= '0;
		@(posedge clk_in);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp,
		input string what);
		wb(idx, 1'h0, 8'h00);
		check(q, exp, what);
	endtask

	// Octet taken from mid-octet samples, clear of edge uncertainty
	task automatic oct(input logic [63:0] f, input int o,
		input logic [7:0] exp, input string what);
		check(f[16 * o + 3 +: 8], exp, what);
	endtask

	// Frame data is built from the previous frame, so settle for three
	task automatic frames(input int n);
		repeat (n) @(posedge p_fs);
		@(posedge clk_in);
	endtask

	// One frame window of port A clock, sync transfer and port A data
	task automatic scan();
		logic last;
		nirq = 0;
		pirq = -1;
		nrise = 0;
		prise = -1;
		nhi = 0;
		ntx0 = 0;
		nld = 0;
		nld1 = 0;
		@(posedge p_fs);
		@(posedge clk_in);
		last = pa_clk;
		for (int i = 0; i < 1024; i++) begin
			if (irq === 1'h1) begin
				nirq++;
				pirq = i;
			end
			if (pa_clk === 1'h1 && last === 1'h0) begin
				nrise++;
				prise = i;
			end
			nhi += (pa_clk === 1'h1);
			ntx0 += (pa_tx !== 1'h1);
			nld += (ld_oe_n === 1'h0);
			nld1 += (ld_oe_n === 1'h0 && ld_o === 1'h1);
			last = pa_clk;
			@(posedge clk_in);
		end
	endtask

	initial begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		@(posedge clk_in);
		rd(IDX_SPC, 8'h00, "connect reset");
		rd(IDX_ADF, 8'h00, "mode select reset");
		wb(6'h00, 1'h1, 8'hA5);
		rd(6'h00, 8'h00, "unmapped place");
		for (int s = 0; s < 2; s++) begin
			d_stop <= s[0];
			frames(3);
			oct(dfr, 0, 8'hFF, "idle B1");
			oct(dfr, 1, 8'hFF, "idle B2");
			check(dfr[44:33], s ? 12'hFFF : 12'hF9F, "monitor");
			oct(dfr, 3, 8'hFF, "control octet");
		end
		$display("test done: idle frame");
		wb(IDX_CMD, 1'h1, 8'h00);
		frames(3);
		oct(ufr, 3, 8'h00, "upstream control");
		oct(ufr, 2, 8'hFF, "upstream monitor");
		check(up_o, 1'h0, "open drain level");
		$display("test done: upstream");
		// Misrouting shows as all ones, the right source as zeros
		for (int ch = 0; ch < 2; ch++) begin
			for (int c = 0; c < 4; c++) begin
				link_drv <= (c != 1);
				pa_rx <= (c != 2);
				wb(IDX_SPC, 1'h1,
					ch ? {4'h0, c[1:0], 2'h0} : {6'h00, c[1:0]});
				frames(3);
				oct(dfr, ch, c ? 8'h00 : 8'hFF, "routed");
				oct(dfr, 1 - ch, 8'hFF, "other channel");
			end
		end
		// Wide option lets B2 follow the B1 connect bits
		link_drv <= 1'h0;
		wb(IDX_ADF, 1'h1, 8'h04);
		wb(IDX_SPC, 1'h1, 8'h01);
		frames(3);
		oct(dfr, 1, 8'h00, "wide B2");
		wb(IDX_ADF, 1'h1, 8'h00);
		$display("test done: routes");
		wb(IDX_SPC, 1'h1, 8'h00);
		for (int v = 0; v < 2; v++) begin
			link_drv <= v[0];
			frames(3);
			for (int r = 0; r < 4; r++)
				rd(IDX_SIG + 6'(r), {8{v[0]}}, "link byte");
		end
		rd(IDX_CAP1, 8'h00, "B1 capture");
		rd(IDX_CAP2, 8'h00, "B2 capture");
		$display("test done: link bytes");
		wb(IDX_CH1, 1'h1, 8'hFF);
		for (int m = 0; m < 3; m++) begin
			wb(IDX_STC, 1'h1,
				m == 0 ? 8'h00 : {6'h00, m == 2, 1'h1});
			frames(1);
			scan();
			check(nirq, m != 0, "sync transfer count");
			if (m != 0)
				check(m == 2 ? pirq >= 480 && pirq < 600 : pirq < 64,
					1'h1, "sync transfer point");
			check(nrise, 16, "port A clock");
			check(nld, 512, "link transmit half");
			check(nld1, 128, "link B1 from register");
			rd(IDX_STAT, {6'h00, 1'h1, m != 0}, "valid flag");
			rd(IDX_STAT, 8'h02, "valid flag cleared");
		end
		$display("test done: sync transfer");
		fsd_route <= 1'h1;
		wb(IDX_SPC, 1'h1, 8'h10);
		frames(2);
		scan();
		check(nrise, 1, "delayed frame edges");
		check(nhi, 512, "delayed frame width");
		check(prise >= 128 && prise < 144, 1'h1, "delayed frame lag");
		check(ntx0, 0, "port A idle");
		wb(IDX_SPC, 1'h1, 8'h00);
		fsd_route <= 1'h0;
		$display("test done: timing mode 1");
		wb(IDX_ADF, 1'h1, 8'h09);
		repeat (8) begin
			repeat (100) @(posedge clk_in);
			check({bc_oe_n, fa_oe_n, fb_oe_n}, 3'h0, "drivers on");
			check(fa_o ^ fb_o, 1'h1, "strobe polarity");
		end
		// Five whole periods of the generated clock, any phase
		nhi = 0;
		repeat (10 * DCL_HALF_CYC) begin
			@(posedge clk_in);
			nhi += (bc_o === 1'h1);
		end
		check(nhi, 5 * DCL_HALF_CYC, "bit clock duty");
		wb(IDX_ADF, 1'h1, 8'h00);
		repeat (4) @(posedge clk_in);
		check({bc_oe_n, fa_oe_n, fb_oe_n}, 3'h7, "drivers off");
		$display("test done: terminal mode");
		conclude();
	end

	// About 60 frames of work; this leaves ample margin
	initial begin
		repeat (90000) @(posedge clk_in);
		err_total++;
		conclude();
	end
endmodule // testbench

`default_nettype wire
